// ---- bench/frsc_cal_model.sv ----
// Stand-in for the analog calibrator that answers each calibration stage
`timescale 1ns/1ps
module frsc_cal_model
  import frsc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       pump_cal_run,
  input  wire logic       osc_cal_run,
  input  wire logic       slow,
  input  wire logic [4:0] pump_result,
  input  wire logic [4:0] osc_result,
  output logic            cal_stage_done,
  output logic      [4:0] cal_stage_result
);
  int wait_cnt;

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_cnt = 0;
      cal_stage_done <= 1'b0;
      cal_stage_result <= 5'h15;
    end
    else
    begin
      cal_stage_done <= 1'b0;
      // Result toggles outside the pulse so a late sample never looks valid
      cal_stage_result <= ~cal_stage_result;
      if ((pump_cal_run || osc_cal_run) && !cal_stage_done)
      begin
        wait_cnt = wait_cnt + 1;
        if (wait_cnt >= (slow ? 12 : 2))
        begin
          wait_cnt = 0;
          cal_stage_done <= 1'b1;
          cal_stage_result <= pump_cal_run ? pump_result : osc_result;
        end
      end
      else
        wait_cnt = 0;
    end
  end
endmodule

// ---- bench/frsc_regs_chk.sv ----
// Concurrent checks on the ports of the register group
`timescale 1ns/1ps
module frsc_regs_chk
  import frsc_pkg::*;
(
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] tx_lo_buffer_bias,
  input wire logic       tx_active,
  input wire logic       amplitude_keyed,
  input wire logic       tx_symbol,
  input wire logic [2:0] power_level_table_index,
  input wire logic       pa_ramp_settled,
  input wire logic       cal_stage_done,
  input wire logic [4:0] cal_stage_result,
  input wire logic       pump_cal_run,
  input wire logic       osc_cal_run,
  input wire logic       cal_done,
  input wire logic [3:0] pump_current_code,
  input wire logic [4:0] oscillator_current,
  input wire logic       oscillator_high_core_select,
  input wire logic       oscillator_override_held
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  wire rd_en = clk_en && reg_rd;
  wire wr_en = clk_en && reg_wr;

  // ****************************
  // Calibration steps
  // ****************************
  // Software write in the same cycle wins, so it is excluded here
  sequence osc_taken;
    clk_en && cal_stage_done && osc_cal_run && !(wr_en && reg_addr == ADDR_SYNTH_CAL_OSC);
  endsequence
  sequence osc_landed;
    oscillator_current == $past(cal_stage_result) ##0 cal_done ##1 !cal_done;
  endsequence

  // ****************************
  // Assertions
  // ****************************
  unmapped_zero_a: assert property (rd_en && (reg_addr < ADDR_RX_FRONT_END_BIAS ||
    reg_addr > ADDR_SYNTH_CAL_OSC) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  unused_bits_a: assert property (rd_en && reg_addr == ADDR_TX_FRONT_END_CFG
    |=> (reg_rdata & 8'hC8) == 8'h00) else $error("unused transmit bits read nonzero");
  tx_lo_write_a: assert property (wr_en && reg_addr == ADDR_TX_FRONT_END_CFG
    |=> tx_lo_buffer_bias == $past(reg_wdata[5:4])) else $error("transmit buffer bias not written");
  ramp_step_a: assert property ($changed(power_level_table_index) |->
    {1'b0, power_level_table_index} == {1'b0, $past(power_level_table_index)} + 4'h1 ||
    {1'b0, $past(power_level_table_index)} == {1'b0, power_level_table_index} + 4'h1) else $error("ramp jumped");
  keyed_zero_a: assert property (tx_active && amplitude_keyed && !tx_symbol && pa_ramp_settled
    |-> power_level_table_index == 3'h0) else $error("zero symbol not on entry zero");
  ramp_idle_a: assert property (!tx_active && pa_ramp_settled
    |-> power_level_table_index == 3'h0) else $error("idle power not ramped down");
  pump_result_a: assert property (clk_en && cal_stage_done && pump_cal_run && !wr_en
    |=> pump_current_code == $past(cal_stage_result[3:0])) else $error("pump code not stored");
  osc_result_a: assert property (osc_taken |=> osc_landed) else $error("oscillator result lost");
  override_skip_a: assert property (oscillator_override_held && clk_en &&
    !(wr_en && reg_addr == ADDR_SYNTH_CAL_OSC) |=> $stable(oscillator_current)) else $error("override ignored");
  core_select_a: assert property (wr_en && reg_addr == ADDR_SYNTH_CAL_OSC
    |=> oscillator_high_core_select == $past(reg_wdata[5])) else $error("core select not written");
endmodule

bind frsc_regs frsc_regs_chk chk_u (.clock, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .tx_lo_buffer_bias, .tx_active, .amplitude_keyed, .tx_symbol, .power_level_table_index,
  .pa_ramp_settled, .cal_stage_done, .cal_stage_result, .pump_cal_run, .osc_cal_run, .cal_done,
  .pump_current_code, .oscillator_current, .oscillator_high_core_select, .oscillator_override_held);

// ---- bench/frsc_regs_test.sv ----
// Self-checking bench for the front-end and calibration register group
`timescale 1ns/1ps
module frsc_regs_test
  import frsc_pkg::*;
;
  logic       clock = 1'b0, nrst = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic       tx_active = 1'b0, amplitude_keyed = 1'b0, tx_symbol = 1'b0, cal_start = 1'b0, slow = 1'b0;
  logic [4:0] pump_result = 5'h00, osc_result = 5'h00, cal_stage_result, oscillator_current;
  logic [1:0] input_amp_bias, amp_to_mixer_bias, rx_lo_buffer_bias, mixer_bias, tx_lo_buffer_bias, pump_cal_config;
  logic [2:0] power_level_table_index;
  logic [3:0] pump_current_code;
  logic       reg_rvalid, pa_ramp_settled, cal_stage_done, pump_cal_run, osc_cal_run, cal_busy, cal_done;
  logic       oscillator_high_core_select, oscillator_override_held, pump_seen;
  int         bad_count = 0, checks = 0;
  logic [5:0] addr_tab [5] = '{6'h21, 6'h22, 6'h23, 6'h24, 6'h25};
  logic [7:0] rst_tab  [5] = '{8'h56, 8'h10, 8'hA9, 8'h0A, 8'h00};
  logic [7:0] mask_tab [5] = '{8'hFF, 8'h37, 8'hFF, 8'h3F, 8'h00};

  // Short ramp step keeps the run brief
  frsc_regs #(.RAMP_STEPS(2)) dut_u (.clock, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .input_amp_bias, .amp_to_mixer_bias, .rx_lo_buffer_bias, .mixer_bias,
    .tx_lo_buffer_bias, .tx_active, .amplitude_keyed, .tx_symbol, .power_level_table_index,
    .pa_ramp_settled, .cal_start, .cal_stage_done, .cal_stage_result, .pump_cal_run, .osc_cal_run,
    .cal_busy, .cal_done, .pump_cal_config, .pump_current_code, .oscillator_current,
    .oscillator_high_core_select, .oscillator_override_held);
  frsc_cal_model model_u (.clock, .nrst, .pump_cal_run, .osc_cal_run, .slow, .pump_result, .osc_result,
    .cal_stage_done, .cal_stage_result);

  always #2 clock = ~clock;

  // ****************************
  // Access tasks
  // ****************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Idle cycle after each strobe so no strobe is set twice in one step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    check({7'h00, reg_rvalid}, 8'h01, "read valid");
    d = reg_rdata;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input string what);
    logic [7:0] v;
    rd(a, v);
    check(v, e, what);
  endtask
  task automatic settle();
    int n;
    n = 0;
    cyc(1);
    while (pa_ramp_settled !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic run_cal(input logic sl);
    int n;
    n = 0;
    slow = sl;
    pump_seen = 1'b0;
    cal_start = 1'b1;
    cyc(1);
    cal_start = 1'b0;
    check({7'h00, cal_busy}, 8'h01, "calibration busy");
    while (cal_done !== 1'b1 && n < 300)
    begin
      pump_seen |= pump_cal_run;
      cyc(1);
      n++;
    end
    check({6'h00, cal_busy, cal_done}, 8'h01, "calibration done");
    cyc(1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************
  // Scenarios
  // ****************************
  initial
  begin
    logic [7:0] save_pump, save_osc;
    repeat (4) @(posedge clock);
    #1;
    nrst = 1'b1;
    foreach (addr_tab[i]) rd_chk(addr_tab[i], rst_tab[i], "reset value");
    foreach (addr_tab[i])
    begin
      wr(addr_tab[i], 8'hFF);
      rd_chk(addr_tab[i], mask_tab[i], "ones through mask");
      wr(addr_tab[i], 8'h00);
      rd_chk(addr_tab[i], 8'h00, "zeros");
    end
    wr(ADDR_RX_FRONT_END_BIAS, 8'h1B);
    check({input_amp_bias, amp_to_mixer_bias, rx_lo_buffer_bias, mixer_bias}, 8'h1B, "rx biases");
    wr(ADDR_TX_FRONT_END_CFG, 8'hE5);
    check({6'h00, tx_lo_buffer_bias}, 8'h02, "tx buffer bias");
    tx_active = 1'b1;
    settle();
    check({5'h00, power_level_table_index}, 8'h05, "ramp up");
    amplitude_keyed = 1'b1;
    settle();
    check({5'h00, power_level_table_index}, 8'h00, "zero symbol");
    tx_symbol = 1'b1;
    settle();
    check({5'h00, power_level_table_index}, 8'h05, "one symbol");
    amplitude_keyed = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_TX_FRONT_END_CFG, 8'h20 | 8'(i));
      settle();
      check({5'h00, power_level_table_index}, 8'(i), "indexed entry");
    end
    clk_en = 1'b0;
    tx_active = 1'b0;
    cyc(20);
    check({5'h00, power_level_table_index}, 8'h07, "frozen ramp");
    clk_en = 1'b1;
    settle();
    check({5'h00, power_level_table_index}, 8'h00, "ramp down");
    wr(ADDR_SYNTH_CAL_PUMP, 8'hA9);
    check({6'h00, pump_cal_config}, 8'h02, "pump config");
    wr(ADDR_SYNTH_CAL_OSC, 8'h2C);
    check({7'h00, oscillator_high_core_select}, 8'h01, "high core");
    pump_result = 5'h05;
    osc_result = 5'h11;
    run_cal(1'b0);
    check({4'h0, pump_current_code}, 8'h05, "pump result");
    check({3'h0, oscillator_current}, 8'h0C, "override kept");
    check({7'h00, oscillator_override_held}, 8'h00, "override released");
    pump_result = 5'h1E;
    run_cal(1'b1);
    check({4'h0, pump_current_code}, 8'h0E, "pump low bits");
    rd_chk(ADDR_SYNTH_CAL_OSC, 8'h31, "fresh oscillator result");
    rd(ADDR_SYNTH_CAL_PUMP, save_pump);
    rd(ADDR_SYNTH_CAL_OSC, save_osc);
    wr(ADDR_SYNTH_CAL_PUMP, 8'h80);
    wr(ADDR_SYNTH_CAL_OSC, 8'h01);
    wr(ADDR_SYNTH_CAL_PUMP, save_pump);
    wr(ADDR_SYNTH_CAL_OSC, save_osc);
    rd_chk(ADDR_SYNTH_CAL_PUMP, 8'hAE, "restored pump word");
    check({3'h0, oscillator_current}, 8'h11, "restored oscillator");
    wr(ADDR_SYNTH_CAL_PUMP, 8'h89);
    run_cal(1'b0);
    check({7'h00, pump_seen}, 8'h00, "pump stage skipped");
    check({4'h0, pump_current_code}, 8'h09, "pump code kept");
    end_of_test();
  end

  initial
  begin
    #20000;
    bad_count++;
    end_of_test();
  end
endmodule

// ---- design/frsc_pa_ramp.sv ----
// Power-level table index stepper for ramping and amplitude shaping
`timescale 1ns/1ps
module frsc_pa_ramp
  import frsc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = RAMP_STEP_CYCLES
)
(
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire logic  clk_en,
  frsc_ramp_if.ramp  rif
);

  localparam int unsigned CNT_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  logic [TX_POWER_INDEX_W-1:0] level;
  logic [TX_POWER_INDEX_W-1:0] next_level;
  logic [CNT_W-1:0]            step_cnt;
  logic [CNT_W-1:0]            next_step_cnt;
  logic [TX_POWER_INDEX_W-1:0] target;

  // ****************************************************************
  // Target and stepping
  // ****************************************************************
  always_comb
  begin
    if (!rif.tx_active)
      target = PA_INDEX_ZERO;
    else if (rif.amplitude_keyed)
      target = rif.tx_symbol ? rif.power_index : PA_INDEX_ZERO;
    else
      target = rif.power_index;
    next_level    = level;
    next_step_cnt = step_cnt;
    // One entry per step, so every entry from zero to the index is visited
    if (level == target)
      next_step_cnt = CNT_ZERO;
    else if (step_cnt == CNT_LAST)
    begin
      next_step_cnt = CNT_ZERO;
      next_level    = (level < target) ? level + 3'h1 : level - 3'h1;
    end
    else
      next_step_cnt = step_cnt + CNT_W'(1);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      level    <= PA_INDEX_ZERO;
      step_cnt <= CNT_ZERO;
    end
    else if (clk_en)
    begin
      level    <= next_level;
      step_cnt <= next_step_cnt;
    end
  end

  assign rif.table_index = level;
  assign rif.settled     = (level == target);

endmodule

// ---- design/frsc_regs.sv ----
// Front-end bias, transmit power and synthesizer calibration register group
`timescale 1ns/1ps
module frsc_regs
  import frsc_pkg::*;
#(
  parameter int unsigned RAMP_STEPS = RAMP_STEP_CYCLES
)
(
  input  wire logic                           clock,
  input  wire logic                           nrst,
  input  wire logic                           clk_en,
  // Register port from the serial interface engine
  input  wire logic [ADDR_W-1:0]              reg_addr,
  input  wire logic [DATA_W-1:0]              reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [DATA_W-1:0]              reg_rdata,
  output logic                                reg_rvalid,
  // Receive front end
  output logic      [BIAS_W-1:0]              input_amp_bias,
  output logic      [BIAS_W-1:0]              amp_to_mixer_bias,
  output logic      [BIAS_W-1:0]              rx_lo_buffer_bias,
  output logic      [BIAS_W-1:0]              mixer_bias,
  // Transmit front end
  output logic      [BIAS_W-1:0]              tx_lo_buffer_bias,
  input  wire logic                           tx_active,
  input  wire logic                           amplitude_keyed,
  input  wire logic                           tx_symbol,
  output logic      [TX_POWER_INDEX_W-1:0]    power_level_table_index,
  output logic                                pa_ramp_settled,
  // Synthesizer calibration
  input  wire logic                           cal_start,
  input  wire logic                           cal_stage_done,
  input  wire logic [CAL_RESULT_W-1:0]        cal_stage_result,
  output logic                                pump_cal_run,
  output logic                                osc_cal_run,
  output logic                                cal_busy,
  output logic                                cal_done,
  output logic      [BIAS_W-1:0]              pump_cal_config,
  output logic      [PUMP_CURRENT_CODE_W-1:0] pump_current_code,
  output logic      [OSC_CURRENT_W-1:0]       oscillator_current,
  output logic                                oscillator_high_core_select,
  output logic                                oscillator_override_held
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Decode shared by the write path and the read path
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  // Writable bits take the new value, the rest stay zero
  function automatic logic [DATA_W-1:0] masked(input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] m);
    masked = d & m;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [DATA_W-1:0]        rx_front_end_bias;
  logic [DATA_W-1:0]        next_rx_front_end_bias;
  logic [DATA_W-1:0]        tx_front_end_config;
  logic [DATA_W-1:0]        next_tx_front_end_config;
  logic [DATA_W-1:0]        synth_cal_pump_word;
  logic [DATA_W-1:0]        next_synth_cal_pump_word;
  logic [DATA_W-1:0]        synth_cal_oscillator_word;
  logic [DATA_W-1:0]        next_synth_cal_oscillator_word;
  logic [DATA_W-1:0]        next_reg_rdata;
  logic                     next_reg_rvalid;
  logic                     osc_override;
  logic                     next_osc_override;
  frsc_cal_state_t          cal_state;
  frsc_cal_state_t          next_cal_state;
  logic                     next_cal_done;
  logic                     pump_stage_enabled;
  logic                     wr_rx;
  logic                     wr_tx;
  logic                     wr_pump;
  logic                     wr_osc;

  frsc_ramp_if rif ();

  assign wr_rx   = reg_wr && hit(reg_addr, ADDR_RX_FRONT_END_BIAS);
  assign wr_tx   = reg_wr && hit(reg_addr, ADDR_TX_FRONT_END_CFG);
  assign wr_pump = reg_wr && hit(reg_addr, ADDR_SYNTH_CAL_PUMP);
  assign wr_osc  = reg_wr && hit(reg_addr, ADDR_SYNTH_CAL_OSC);

  assign pump_stage_enabled = |synth_cal_pump_word[PUMP_CAL_STAGE_EN_LSB +: BIAS_W];

  // ****************************************************************
  // Calibration sequencer
  // ****************************************************************
  always_comb
  begin
    next_cal_state = cal_state;
    next_cal_done  = 1'b0;
    unique case (cal_state)
      FRSC_CAL_IDLE:
      begin
        if (cal_start)
        begin
          // Disabled pump stage goes straight to the oscillator stage
          if (pump_stage_enabled)
            next_cal_state = FRSC_CAL_PUMP;
          else
            next_cal_state = FRSC_CAL_OSC;
        end
      end
      FRSC_CAL_PUMP:
      begin
        if (cal_stage_done)
          next_cal_state = FRSC_CAL_OSC;
      end
      FRSC_CAL_OSC:
      begin
        // A held override stands in for the fresh measurement
        if (cal_stage_done || osc_override)
        begin
          next_cal_state = FRSC_CAL_IDLE;
          next_cal_done  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cal_state <= FRSC_CAL_IDLE;
      cal_done  <= 1'b0;
    end
    else if (clk_en)
    begin
      cal_state <= next_cal_state;
      cal_done  <= next_cal_done;
    end
  end

  assign pump_cal_run = (cal_state == FRSC_CAL_PUMP);
  assign osc_cal_run  = (cal_state == FRSC_CAL_OSC) && !osc_override;
  assign cal_busy     = (cal_state != FRSC_CAL_IDLE);

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_comb
  begin
    next_rx_front_end_bias         = rx_front_end_bias;
    next_tx_front_end_config       = tx_front_end_config;
    next_synth_cal_pump_word       = synth_cal_pump_word;
    next_synth_cal_oscillator_word = synth_cal_oscillator_word;
    next_osc_override              = osc_override;

    if (wr_rx)
      next_rx_front_end_bias = masked(reg_wdata, MASK_RX_FRONT_END_BIAS);
    if (wr_tx)
      next_tx_front_end_config = masked(reg_wdata, MASK_TX_FRONT_END_CFG);

    // Hardware result first, so a software write in the same cycle wins
    if (pump_cal_run && cal_stage_done)
      next_synth_cal_pump_word[PUMP_CURRENT_CODE_LSB +: PUMP_CURRENT_CODE_W] =
        cal_stage_result[PUMP_CURRENT_CODE_W-1:0];
    if (wr_pump)
      next_synth_cal_pump_word = masked(reg_wdata, MASK_SYNTH_CAL_PUMP);

    if (osc_cal_run && cal_stage_done)
      next_synth_cal_oscillator_word[OSC_CURRENT_LSB +: OSC_CURRENT_W] =
        cal_stage_result[OSC_CURRENT_W-1:0];
    // Override lasts for one calibration, then fresh results return
    if (next_cal_done)
      next_osc_override = 1'b0;
    if (wr_osc)
    begin
      next_synth_cal_oscillator_word = masked(reg_wdata, MASK_SYNTH_CAL_OSC);
      next_osc_override              = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_front_end_bias         <= RST_RX_FRONT_END_BIAS;
      tx_front_end_config       <= RST_TX_FRONT_END_CFG;
      synth_cal_pump_word       <= RST_SYNTH_CAL_PUMP;
      synth_cal_oscillator_word <= RST_SYNTH_CAL_OSC;
      osc_override              <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_front_end_bias         <= next_rx_front_end_bias;
      tx_front_end_config       <= next_tx_front_end_config;
      synth_cal_pump_word       <= next_synth_cal_pump_word;
      synth_cal_oscillator_word <= next_synth_cal_oscillator_word;
      osc_override              <= next_osc_override;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb
  begin
    next_reg_rdata  = reg_rdata;
    next_reg_rvalid = reg_rd;
    if (reg_rd)
    begin
      if (hit(reg_addr, ADDR_RX_FRONT_END_BIAS))
        next_reg_rdata = rx_front_end_bias;
      else if (hit(reg_addr, ADDR_TX_FRONT_END_CFG))
        next_reg_rdata = masked(tx_front_end_config, MASK_TX_FRONT_END_CFG);
      else if (hit(reg_addr, ADDR_SYNTH_CAL_PUMP))
        next_reg_rdata = synth_cal_pump_word;
      else if (hit(reg_addr, ADDR_SYNTH_CAL_OSC))
        next_reg_rdata = masked(synth_cal_oscillator_word, MASK_SYNTH_CAL_OSC);
      else
        next_reg_rdata = READ_UNMAPPED;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata  <= READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rdata  <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // ****************************************************************
  // Power ramp
  // ****************************************************************
  assign rif.power_index     = tx_front_end_config[TX_POWER_INDEX_LSB +: TX_POWER_INDEX_W];
  assign rif.amplitude_keyed = amplitude_keyed;
  assign rif.tx_active       = tx_active;
  assign rif.tx_symbol       = tx_symbol;

  frsc_pa_ramp #(
    .STEP_CYCLES (RAMP_STEPS)
  ) u_ramp (
    .clock  (clock),
    .nrst   (nrst),
    .clk_en (clk_en),
    .rif    (rif.ramp)
  );

  assign power_level_table_index = rif.table_index;
  assign pa_ramp_settled         = rif.settled;

  // ****************************************************************
  // Analog controls
  // ****************************************************************
  // Fields drive the analog blocks straight from the register flops
  assign input_amp_bias              = rx_front_end_bias[INPUT_AMP_BIAS_LSB +: BIAS_W];
  assign amp_to_mixer_bias           = rx_front_end_bias[AMP_TO_MIXER_BIAS_LSB +: BIAS_W];
  assign rx_lo_buffer_bias           = rx_front_end_bias[RX_LO_BUFFER_BIAS_LSB +: BIAS_W];
  assign mixer_bias                  = rx_front_end_bias[MIXER_BIAS_LSB +: BIAS_W];
  assign tx_lo_buffer_bias           = tx_front_end_config[TX_LO_BUFFER_BIAS_LSB +: BIAS_W];
  assign pump_cal_config             = synth_cal_pump_word[PUMP_CAL_CONFIG_LSB +: BIAS_W];
  // Current is I0 * 2^(code/4); the analog side does the exponent
  assign pump_current_code           = synth_cal_pump_word[PUMP_CURRENT_CODE_LSB +: PUMP_CURRENT_CODE_W];
  assign oscillator_current          = synth_cal_oscillator_word[OSC_CURRENT_LSB +: OSC_CURRENT_W];
  assign oscillator_high_core_select = synth_cal_oscillator_word[OSC_HIGH_CORE_BIT];
  assign oscillator_override_held    = osc_override;

endmodule

// ---- pkg/frsc_pkg.sv ----
// Constants and types of the front-end and synthesizer calibration register group
//
// Contract
// - Three-bit power index selects one table entry
// - Amplitude keying: one symbol uses indexed entry
// - Amplitude keying: zero symbol uses entry zero
// - Step entries zero..index for shaping and ramps
// - Pump enable zero skips charge pump stage
// - Low pump bits hold exponential current code
// - Oscillator current: result, or software override
// - Bit five selects high or low core
// - Receive register holds four two-bit biases
// - Transmit register holds LO buffer bias
package frsc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_RX_FRONT_END_BIAS  = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_TX_FRONT_END_CFG   = 6'h22;
  localparam logic [ADDR_W-1:0] ADDR_SYNTH_CAL_PUMP     = 6'h23;
  localparam logic [ADDR_W-1:0] ADDR_SYNTH_CAL_OSC      = 6'h24;

  // ****************************************************************
  // Reset values and writable-bit masks
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_RX_FRONT_END_BIAS   = 8'h56;
  localparam logic [DATA_W-1:0] RST_TX_FRONT_END_CFG    = 8'h10;
  localparam logic [DATA_W-1:0] RST_SYNTH_CAL_PUMP      = 8'hA9;
  localparam logic [DATA_W-1:0] RST_SYNTH_CAL_OSC       = 8'h0A;

  localparam logic [DATA_W-1:0] MASK_RX_FRONT_END_BIAS  = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_TX_FRONT_END_CFG   = 8'h37;
  localparam logic [DATA_W-1:0] MASK_SYNTH_CAL_PUMP     = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_SYNTH_CAL_OSC      = 8'h3F;
  localparam logic [DATA_W-1:0] READ_UNMAPPED           = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned INPUT_AMP_BIAS_LSB     = 6;
  localparam int unsigned AMP_TO_MIXER_BIAS_LSB  = 4;
  localparam int unsigned RX_LO_BUFFER_BIAS_LSB  = 2;
  localparam int unsigned MIXER_BIAS_LSB         = 0;
  localparam int unsigned BIAS_W                 = 2;
  localparam int unsigned TX_LO_BUFFER_BIAS_LSB  = 4;
  localparam int unsigned TX_POWER_INDEX_LSB     = 0;
  localparam int unsigned TX_POWER_INDEX_W       = 3;
  localparam int unsigned PUMP_CAL_CONFIG_LSB    = 6;
  localparam int unsigned PUMP_CAL_STAGE_EN_LSB  = 4;
  localparam int unsigned PUMP_CURRENT_CODE_LSB  = 0;
  localparam int unsigned PUMP_CURRENT_CODE_W    = 4;
  localparam int unsigned OSC_HIGH_CORE_BIT      = 5;
  localparam int unsigned OSC_CURRENT_LSB        = 0;
  localparam int unsigned OSC_CURRENT_W          = 5;
  localparam int unsigned CAL_RESULT_W           = 5;

  // ****************************************************************
  // Power ramp timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS          = 4;
  localparam int unsigned RAMP_STEP_NS           = 32;
  localparam int unsigned RAMP_STEP_CYCLES       = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [TX_POWER_INDEX_W-1:0] PA_INDEX_ZERO = 3'h0;

  // ****************************************************************
  // Calibration sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    FRSC_CAL_IDLE,
    FRSC_CAL_PUMP,
    FRSC_CAL_OSC
  } frsc_cal_state_t;

endpackage

// ---- pkg/frsc_ramp_if.sv ----
// Carrier between the register group and the power ramp stepper
`timescale 1ns/1ps
interface frsc_ramp_if
  import frsc_pkg::*;
();
  logic [TX_POWER_INDEX_W-1:0] power_index;
  logic                        amplitude_keyed;
  logic                        tx_active;
  logic                        tx_symbol;
  logic [TX_POWER_INDEX_W-1:0] table_index;
  logic                        settled;

  modport regs
  (
    output power_index,
    output amplitude_keyed,
    output tx_active,
    output tx_symbol,
    input  table_index,
    input  settled
  );

  modport ramp
  (
    input  power_index,
    input  amplitude_keyed,
    input  tx_active,
    input  tx_symbol,
    output table_index,
    output settled
  );
endinterface
